// ### logic/rfi_dev.sv
// Functional notes
// - Host never writes rate codes 001,010,011,111
// - Drive code 11: high asserted, else released
// - Drive code 10: low asserted, else released
// - Drive code 01: high asserted, low idle
// - Drive code 00: low asserted, high idle
// - Host writes reserved bits as zero
// - Control bit 3 selects byte or serial path
// - Serial mode host handles bit timing
// - Byte mode preferred over serial mode
// - Gap field sets invalid bits before frame end
// - Gap counted in receive after valid bit
// - Frame end moves partial byte to channel
// - Gap zero ends at first invalid bit
// - Enable bit 7 gates channel B underflow
// - Enable bit 6 gates channel B overflow
// - Enable bit 5 gates channel B frame end
// - Status read clears pending frame end
// - Enable bit 4 gates channel B full
// - Enable bits 3..0 same for channel A
//
// Implementation choice: the Avalon-MM interface to the registers.
`include "rfi_params.svh"
`timescale 1ns/100ps
`default_nettype none
module rfi_dev
    import rfi_pkg::*;
#(
    parameter int NCH = 2
) (
    input wire logic CLK,
    input wire logic RSTN,
    rfi_if.dev LINK,
    input wire logic RX_MODE,
    input wire logic [NCH-1:0] RX_TICK,
    input wire logic [NCH-1:0] RX_OK,
    input wire logic [NCH-1:0] RX_BIT,
    output logic [2*NCH-1:0] EOF_SEEN
);
    logic [1:0] cfg_r, cfg_nxt;
    logic [3:0] bpc_r, bpc_nxt;
    logic [7:0] ien_r, ien_nxt;
    logic [NCH-1:0][7:0] sh_r, sh_nxt;
    logic [NCH-1:0][7:0] data_r, data_nxt;
    logic [NCH-1:0][2:0] cnt_r, cnt_nxt;
    logic [NCH-1:0][2:0] gap_r, gap_nxt;
    logic [NCH-1:0] seen_r, seen_nxt;
    logic [NCH-1:0] valid_r, valid_nxt;
    logic [NCH-1:0] full_r, full_nxt;
    logic [NCH-1:0] eof_r, eof_nxt;
    logic [NCH-1:0] ovf_r, ovf_nxt;
    logic [NCH-1:0] udf_r, udf_nxt;
    logic [NCH-1:0] rd_data;
    logic [NCH-1:0] load;
    logic [NCH-1:0] eof_ev;
    logic [NCH-1:0][7:0] ld_val;
    logic [NCH-1:0] ld_full;
    logic [2*NCH-1:0] eof_seen_r, eof_seen_nxt;
    logic ack_r, ack_nxt;
    rfi_byte_type rdata_r, rdata_nxt;
    logic irq_out_r, irq_out_nxt;
    logic irq_oe_n_r, irq_oe_n_nxt;
    logic ser_d_r, ser_d_nxt;
    logic ser_v_r, ser_v_nxt;
    logic byte_mode;
    logic rd_stat;
    logic pend;
    logic [7:0] src;
    logic [7:0] stat;

    assign byte_mode = bpc_r[`RFI_BPC_BYTE_BIT];
    assign rd_stat = LINK.reg_rd && (LINK.reg_addr == `RFI_ADDR_STAT);
    assign rd_data[0] = LINK.reg_rd && (LINK.reg_addr == `RFI_ADDR_DATA_A);
    assign rd_data[1] = LINK.reg_rd && (LINK.reg_addr == `RFI_ADDR_DATA_B);
    assign src = {udf_r[1], ovf_r[1], eof_r[1], full_r[1],
                  udf_r[0], ovf_r[0], eof_r[0], full_r[0]};
    assign stat = {valid_r[1], ovf_r[1] | udf_r[1], eof_r[1], full_r[1],
                   valid_r[0], ovf_r[0] | udf_r[0], eof_r[0], full_r[0]};
    assign pend = |(src & ien_r);

    // Receivers: byte assembly, gap count, data hand-off
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            sh_nxt[c] = sh_r[c];
            cnt_nxt[c] = cnt_r[c];
            gap_nxt[c] = gap_r[c];
            seen_nxt[c] = seen_r[c];
            load[c] = 1'b0;
            ld_val[c] = sh_r[c];
            ld_full[c] = 1'b0;
            eof_ev[c] = 1'b0;
            if (RX_MODE && RX_TICK[c]) begin
                if (RX_OK[c]) begin
                    seen_nxt[c] = 1'b1;
                    gap_nxt[c] = 3'h0;
                    if (byte_mode) begin
                        sh_nxt[c] = {sh_r[c][6:0], RX_BIT[c]};
                        if (cnt_r[c] == `RFI_LAST_BIT) begin
                            load[c] = 1'b1;
                            ld_val[c] = {sh_r[c][6:0], RX_BIT[c]};
                            ld_full[c] = 1'b1;
                            cnt_nxt[c] = 3'h0;
                            // Old bits must not leak into a later partial byte
                            sh_nxt[c] = 8'h00;
                        end else begin
                            cnt_nxt[c] = cnt_r[c] + 3'h1;
                        end
                    end
                end else if (seen_r[c]) begin
                    // Invalid bits so far exceed the gap field
                    if (gap_r[c] == bpc_r[2:0]) begin
                        eof_ev[c] = 1'b1;
                        seen_nxt[c] = 1'b0;
                        sh_nxt[c] = 8'h00;
                        gap_nxt[c] = 3'h0;
                        cnt_nxt[c] = 3'h0;
                        // Partial byte sits in the low bits
                        load[c] = byte_mode && (cnt_r[c] != 3'h0);
                    end else begin
                        gap_nxt[c] = gap_r[c] + 3'h1;
                    end
                end
            end
        end
    end

    // Sticky flags; a new event beats a same-cycle clear
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            data_nxt[c] = load[c] ? ld_val[c] : data_r[c];
            valid_nxt[c] = load[c] ? ld_full[c] : (valid_r[c] & ~rd_data[c]);
            full_nxt[c] = load[c] | (full_r[c] & ~rd_data[c]);
            ovf_nxt[c] = (load[c] & full_r[c] & ~rd_data[c])
                         | (ovf_r[c] & ~rd_stat);
            udf_nxt[c] = (rd_data[c] & ~full_r[c] & ~load[c])
                         | (udf_r[c] & ~rd_stat);
            eof_nxt[c] = eof_ev[c] | (eof_r[c] & ~rd_stat);
        end
        eof_seen_nxt = {eof_r, full_r};
    end

    // Register port and pin drive
    always_comb begin
        cfg_nxt = cfg_r;
        bpc_nxt = bpc_r;
        ien_nxt = ien_r;
        ack_nxt = LINK.reg_wr | LINK.reg_rd;
        rdata_nxt = 8'h00;
        if (LINK.reg_wr) begin
            case (LINK.reg_addr)
                `RFI_ADDR_CFG: cfg_nxt = LINK.reg_wdata[1:0];
                `RFI_ADDR_BPC: bpc_nxt = LINK.reg_wdata[3:0];
                `RFI_ADDR_IEN: ien_nxt = LINK.reg_wdata;
                default: ;
            endcase
        end
        if (LINK.reg_rd) begin
            case (LINK.reg_addr)
                `RFI_ADDR_CFG: rdata_nxt = {6'h00, cfg_r};
                `RFI_ADDR_BPC: rdata_nxt = {4'h0, bpc_r};
                `RFI_ADDR_IEN: rdata_nxt = ien_r;
                `RFI_ADDR_STAT: rdata_nxt = stat;
                `RFI_ADDR_DATA_A: rdata_nxt = data_r[0];
                `RFI_ADDR_DATA_B: rdata_nxt = data_r[1];
                default: rdata_nxt = 8'h00;
            endcase
        end
        case (cfg_r)
            `RFI_IRQ_SRC: begin
                irq_out_nxt = 1'b1;
                irq_oe_n_nxt = ~pend;
            end
            `RFI_IRQ_DRN: begin
                irq_out_nxt = 1'b0;
                irq_oe_n_nxt = ~pend;
            end
            `RFI_IRQ_CMOS: begin
                irq_out_nxt = pend;
                irq_oe_n_nxt = 1'b0;
            end
            default: begin
                irq_out_nxt = ~pend;
                irq_oe_n_nxt = 1'b0;
            end
        endcase
        // Serial path carries channel A bits only
        ser_v_nxt = RX_MODE & RX_TICK[0] & RX_OK[0] & ~byte_mode;
        ser_d_nxt = ser_v_nxt ? RX_BIT[0] : ser_d_r;
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_r <= `RFI_CFG_RST;
            bpc_r <= `RFI_BPC_RST;
            ien_r <= `RFI_IEN_RST;
            sh_r <= '0;
            data_r <= '0;
            cnt_r <= '0;
            gap_r <= '0;
            seen_r <= '0;
            valid_r <= '0;
            full_r <= '0;
            eof_r <= '0;
            ovf_r <= '0;
            udf_r <= '0;
            eof_seen_r <= '0;
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
            // Reset code 01 idles low; high here would flash a request
            irq_out_r <= 1'b0;
            irq_oe_n_r <= 1'b0;
            ser_d_r <= 1'b0;
            ser_v_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            bpc_r <= bpc_nxt;
            ien_r <= ien_nxt;
            sh_r <= sh_nxt;
            data_r <= data_nxt;
            cnt_r <= cnt_nxt;
            gap_r <= gap_nxt;
            seen_r <= seen_nxt;
            valid_r <= valid_nxt;
            full_r <= full_nxt;
            eof_r <= eof_nxt;
            ovf_r <= ovf_nxt;
            udf_r <= udf_nxt;
            eof_seen_r <= eof_seen_nxt;
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            irq_out_r <= irq_out_nxt;
            irq_oe_n_r <= irq_oe_n_nxt;
            ser_d_r <= ser_d_nxt;
            ser_v_r <= ser_v_nxt;
        end
    end

    assign LINK.reg_ack = ack_r;
    assign LINK.reg_rdata = rdata_r;
    assign LINK.irq_out = irq_out_r;
    assign LINK.irq_oe_n = irq_oe_n_r;
    assign LINK.serial_data_pin = ser_d_r;
    assign LINK.serial_data_valid_pin = ser_v_r;
    assign EOF_SEEN = eof_seen_r;
endmodule : rfi_dev
`default_nettype wire

// ### pkg/rfi_params.svh
`ifndef RFI_PARAMS_SVH
`define RFI_PARAMS_SVH

// Device register indices on the link
`define RFI_ADDR_RATE 8'h04
`define RFI_ADDR_CFG 8'h05
`define RFI_ADDR_BPC 8'h06
`define RFI_ADDR_IEN 8'h07
`define RFI_ADDR_STAT 8'h08
`define RFI_ADDR_DATA_A 8'h09
`define RFI_ADDR_DATA_B 8'h0b

// Reset values
`define RFI_CFG_RST 2'h1
`define RFI_BPC_RST 4'h3
`define RFI_IEN_RST 8'h00

// Field positions and masks
`define RFI_BPC_BYTE_BIT 3
`define RFI_CFG_MASK 8'h03
`define RFI_BPC_MASK 8'h0f
`define RFI_RATE_MASK 8'h07
`define RFI_LAST_BIT 3'h7

// Pin drive codes
`define RFI_IRQ_SRC 2'h3
`define RFI_IRQ_DRN 2'h2
`define RFI_IRQ_CMOS 2'h1
`define RFI_IRQ_INV 2'h0

// Invalid rate codes
`define RFI_RATE_BAD0 3'h1
`define RFI_RATE_BAD1 3'h2
`define RFI_RATE_BAD2 3'h3
`define RFI_RATE_BAD3 3'h7

// Host-side Avalon map
`define RFI_HOST_STAT 5'h10
`define RFI_HOST_SER 5'h11

`endif

// ### pkg/rfi_pkg.sv
`default_nettype none
package rfi_pkg;
    typedef enum {HS_IDLE, HS_WAIT, HS_DONE} rfi_hstate_type;
    typedef logic [7:0] rfi_byte_type;
endpackage : rfi_pkg
`default_nettype wire

// ### pkg/rfi_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rfi_if #(parameter logic IRQ_PULL = 1'b1);
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_ack;
    logic [7:0] reg_rdata;
    logic irq_out;
    logic irq_oe_n;
    logic irq_line;
    logic serial_data_pin;
    logic serial_data_valid_pin;

    // Resistor level when nobody drives the request pin
    assign irq_line = irq_oe_n ? IRQ_PULL : irq_out;

    modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata,
                 output reg_ack, reg_rdata, irq_out, irq_oe_n,
                 serial_data_pin, serial_data_valid_pin);
    modport host (output reg_wr, reg_rd, reg_addr, reg_wdata,
                  input reg_ack, reg_rdata, irq_line,
                  serial_data_pin, serial_data_valid_pin);
endinterface : rfi_if
`default_nettype wire

// ### logic/rfi_host.sv
`include "rfi_params.svh"
`timescale 1ns/100ps
`default_nettype none
module rfi_host
    import rfi_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    rfi_if.host LINK,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    rfi_hstate_type st_r, st_nxt;
    logic wr_r, wr_nxt;
    logic rd_r, rd_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic wait_r, wait_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] ser_r, ser_nxt;
    logic [7:0] wd;
    logic bad_rate;
    logic local_hit;

    assign local_hit = AVS_ADDRESS[4];
    assign bad_rate = (AVS_ADDRESS == `RFI_ADDR_RATE) &&
        (AVS_WRITEDATA[2:0] == `RFI_RATE_BAD0 || AVS_WRITEDATA[2:0] == `RFI_RATE_BAD1 ||
         AVS_WRITEDATA[2:0] == `RFI_RATE_BAD2 || AVS_WRITEDATA[2:0] == `RFI_RATE_BAD3);

    always_comb begin
        // Reserved bits forced to zero before they leave
        case ({3'h0, AVS_ADDRESS})
            `RFI_ADDR_CFG: wd = AVS_WRITEDATA[7:0] & `RFI_CFG_MASK;
            `RFI_ADDR_BPC: wd = AVS_WRITEDATA[7:0] & `RFI_BPC_MASK;
            `RFI_ADDR_RATE: wd = AVS_WRITEDATA[7:0] & `RFI_RATE_MASK;
            default: wd = AVS_WRITEDATA[7:0];
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        wr_nxt = 1'b0;
        rd_nxt = 1'b0;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdat_nxt = rdat_r;
        wait_nxt = 1'b1;
        irq_nxt = LINK.irq_line;
        ser_nxt = ser_r;
        // Serial pins sampled so software sees the bit stream
        if (LINK.serial_data_valid_pin) begin
            ser_nxt = {ser_r[6:0], LINK.serial_data_pin};
        end
        case (st_r)
            HS_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    if (local_hit || (AVS_WRITE && bad_rate)) begin
                        // Invalid rate codes are dropped, never sent
                        case (AVS_ADDRESS)
                            `RFI_HOST_STAT: rdat_nxt = {31'h0, irq_r};
                            `RFI_HOST_SER: rdat_nxt = {24'h0, ser_r};
                            default: rdat_nxt = 32'h0;
                        endcase
                        wait_nxt = 1'b0;
                        st_nxt = HS_DONE;
                    end else begin
                        wr_nxt = AVS_WRITE;
                        rd_nxt = AVS_READ;
                        addr_nxt = {3'h0, AVS_ADDRESS};
                        wdata_nxt = wd;
                        st_nxt = HS_WAIT;
                    end
                end
            end
            HS_WAIT: begin
                if (LINK.reg_ack) begin
                    rdat_nxt = {24'h0, LINK.reg_rdata};
                    wait_nxt = 1'b0;
                    st_nxt = HS_DONE;
                end
            end
            HS_DONE: st_nxt = HS_IDLE;
            default: st_nxt = HS_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r <= HS_IDLE;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
            rdat_r <= 32'h0;
            wait_r <= 1'b1;
            irq_r <= 1'b0;
            ser_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdat_r <= rdat_nxt;
            wait_r <= wait_nxt;
            irq_r <= irq_nxt;
            ser_r <= ser_nxt;
        end
    end

    assign LINK.reg_wr = wr_r;
    assign LINK.reg_rd = rd_r;
    assign LINK.reg_addr = addr_r;
    assign LINK.reg_wdata = wdata_r;
    assign AVS_READDATA = rdat_r;
    assign AVS_WAITREQUEST = wait_r;
endmodule : rfi_host
`default_nettype wire

// ### testbench/rfi_assertions.sv
`include "rfi_params.svh"
`timescale 1ns/100ps
`default_nettype none
module rfi_assertions (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic [7:0] reg_rdata,
    input wire logic irq_out,
    input wire logic irq_oe_n,
    input wire logic irq_line,
    input wire logic serial_data_pin,
    input wire logic serial_data_valid_pin
);
    logic [1:0] cfg_r;
    logic [1:0] cfg_nxt;
    logic [7:0] ien_r;
    logic [7:0] ien_nxt;
    logic byte_r;
    logic byte_nxt;
    logic [1:0] age_r;
    logic [1:0] age_nxt;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // Shadow copy; age hides the one-cycle lag of the pin after a write
    always_comb begin
        cfg_nxt = cfg_r;
        ien_nxt = ien_r;
        byte_nxt = byte_r;
        age_nxt = (age_r == 2'h3) ? age_r : age_r + 2'h1;
        if (reg_wr && reg_addr == `RFI_ADDR_CFG) cfg_nxt = reg_wdata[1:0];
        if (reg_wr && reg_addr == `RFI_ADDR_IEN) ien_nxt = reg_wdata;
        if (reg_wr && reg_addr == `RFI_ADDR_BPC) byte_nxt = reg_wdata[3];
        if (reg_wr && reg_addr inside {`RFI_ADDR_CFG, `RFI_ADDR_BPC, `RFI_ADDR_IEN}) age_nxt = 2'h0;
    end
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_r <= `RFI_CFG_RST;
            ien_r <= `RFI_IEN_RST;
            byte_r <= 1'b0;
            age_r <= 2'h0;
        end else begin
            cfg_r <= cfg_nxt;
            ien_r <= ien_nxt;
            byte_r <= byte_nxt;
            age_r <= age_nxt;
        end
    end
    a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("no acknowledge after request");
    a_ack_caused: assert property (reg_ack |-> $past(reg_wr || reg_rd))
        else $error("acknowledge without request");
    a_src_high: assert property ((cfg_r == `RFI_IRQ_SRC && age_r > 2'h1 && !irq_oe_n) |-> irq_out)
        else $error("open source pin driven low");
    a_drn_low: assert property ((cfg_r == `RFI_IRQ_DRN && age_r > 2'h1 && !irq_oe_n) |-> !irq_out)
        else $error("open drain pin driven high");
    a_cmos_driven: assert property ((!cfg_r[1] && age_r > 2'h1) |-> !irq_oe_n)
        else $error("push-pull pin released");
    a_quiet_pin: assert property ((ien_r == 8'h00 && age_r > 2'h1)
        |-> (cfg_r[1] ? irq_oe_n : (irq_out == !cfg_r[0])))
        else $error("pin asserted with all enables off");
    a_cfg_readback: assert property ((reg_rd && reg_addr == `RFI_ADDR_CFG)
        |=> reg_rdata == {6'h00, cfg_r})
        else $error("configuration read back wrong");
    a_ien_readback: assert property ((reg_rd && reg_addr == `RFI_ADDR_IEN) |=> reg_rdata == ien_r)
        else $error("enable read back wrong");
    a_serial_off: assert property ((byte_r && age_r > 2'h1) |-> !serial_data_valid_pin)
        else $error("serial strobe in byte mode");
    a_rate_legal: assert property ((reg_wr && reg_addr == `RFI_ADDR_RATE)
        |-> !(reg_wdata[2:0] inside {`RFI_RATE_BAD0, `RFI_RATE_BAD1,
                                     `RFI_RATE_BAD2, `RFI_RATE_BAD3}))
        else $error("invalid rate code reached the device");
    c_src_drive: cover property (cfg_r == `RFI_IRQ_SRC && !irq_oe_n && irq_line);
    c_serial_bit: cover property (serial_data_valid_pin && serial_data_pin);
    c_status_rd: cover property (reg_rd && reg_addr == `RFI_ADDR_STAT);
endmodule : rfi_assertions
`default_nettype wire

// ### testbench/test_rx_frame_irq_config.sv
`timescale 1ns/100ps
`default_nettype none
module test_rx_frame_irq_config;
    logic CLK;
    logic RSTN;
    logic rx_mode;
    logic [1:0] rx_tick;
    logic [1:0] rx_ok;
    logic [1:0] rx_bit;
    logic [4:0] av_address;
    logic av_read;
    logic av_write;
    logic [31:0] av_wdata;
    logic [31:0] av_rdata;
    logic av_wait;
    int n_errors;
    int check_count;
    logic [3:0] eof_seen;
    int rate_wr = 0;
    rfi_if #(.IRQ_PULL(1'b1)) link ();
    rfi_dev rfi_dev_inst (.CLK(CLK), .RSTN(RSTN), .LINK(link), .RX_MODE(rx_mode),
        .RX_TICK(rx_tick), .RX_OK(rx_ok), .RX_BIT(rx_bit), .EOF_SEEN(eof_seen));
    rfi_host rfi_host_inst (.CLK(CLK), .RSTN(RSTN), .LINK(link), .AVS_ADDRESS(av_address),
        .AVS_READ(av_read), .AVS_WRITE(av_write), .AVS_WRITEDATA(av_wdata),
        .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait));
    rfi_assertions rfi_assertions_inst (.CLK(CLK), .RSTN(RSTN), .reg_wr(link.reg_wr),
        .reg_rd(link.reg_rd), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
        .reg_ack(link.reg_ack), .reg_rdata(link.reg_rdata), .irq_out(link.irq_out),
        .irq_oe_n(link.irq_oe_n), .irq_line(link.irq_line),
        .serial_data_pin(link.serial_data_pin),
        .serial_data_valid_pin(link.serial_data_valid_pin));
    // Counts rate writes that actually reach the device
    always @(posedge CLK) begin
        if (link.reg_wr && link.reg_addr == 8'h04) rate_wr <= rate_wr + 1;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge CLK);
        av_address <= a;
        av_wdata <= d;
        av_write <= wr;
        av_read <= !wr;
        // Only the watchdog ends a hung wait
        do begin
            @(posedge CLK);
        end while (av_wait !== 1'b0);
        av_write <= 1'b0;
        av_read <= 1'b0;
    endtask : av
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        av(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        av(1'b0, a, 32'h0);
        check(av_rdata, exp);
    endtask : rdc
    task automatic rx(input int ch, input logic ok, input logic b);
        @(posedge CLK);
        rx_tick[ch] <= 1'b1;
        rx_ok[ch] <= ok;
        rx_bit[ch] <= b;
        @(posedge CLK);
        rx_tick[ch] <= 1'b0;
        // Pin copy lags the flags by one cycle, host copy by two
        @(posedge CLK);
    endtask : rx
    task automatic rx_byte(input int ch, input logic [7:0] v);
        for (int i = 7; i >= 0; i--) rx(ch, 1'b1, v[i]);
    endtask : rx_byte
    task automatic t_reset();
        rdc(5'h05, 32'h01);
        rdc(5'h06, 32'h03);
        rdc(5'h07, 32'h00);
        rdc(5'h0c, 32'h00);
        rdc(5'h10, 32'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_eof();
        for (int ch = 0; ch < 2; ch++) begin
            wr(5'h06, 32'h08 | (2 * ch));
            wr(5'h07, 32'h02 << (4 * ch));
            repeat (2 * ch + 1) rx(ch, 1'b0, 1'b0);
            rdc(5'h08, 32'h00);
            rx(ch, 1'b1, 1'b1);
            rx(ch, 1'b1, 1'b0);
            rx(ch, 1'b1, 1'b1);
            repeat (2 * ch) rx(ch, 1'b0, 1'b0);
            rdc(5'h08, 32'h00);
            rx(ch, 1'b0, 1'b0);
            @(posedge CLK);
            check(eof_seen, 32'h5 << ch);
            rdc(5'h10, 32'h01);
            rdc(5'h08, 32'h03 << (4 * ch));
            rdc(5'h08, 32'h01 << (4 * ch));
            rdc(5'h10, 32'h00);
            rdc(5'(5'h09 + 2 * ch), 32'h05);
        end
        $display("test frame end done");
    endtask : t_eof
    task automatic t_drive();
        wr(5'h06, 32'hfb);
        rdc(5'h06, 32'h0b);
        wr(5'h07, 32'h01);
        rx_byte(0, 8'ha5);
        for (int c = 0; c < 4; c++) begin
            wr(5'h05, c);
            rdc(5'h10, c & 1);
        end
        rdc(5'h08, 32'h09);
        rdc(5'h09, 32'ha5);
        for (int c = 0; c < 4; c++) begin
            wr(5'h05, c);
            rdc(5'h10, c != 1);
        end
        wr(5'h05, 32'hfd);
        rdc(5'h05, 32'h01);
        $display("test pin drive done");
    endtask : t_drive
    task automatic t_flow();
        wr(5'h07, 32'h08);
        // An empty read still shows the last byte
        rdc(5'h09, 32'ha5);
        rdc(5'h10, 32'h01);
        rdc(5'h08, 32'h04);
        rdc(5'h10, 32'h00);
        wr(5'h07, 32'h40);
        rx_byte(1, 8'h11);
        rx_byte(1, 8'h22);
        rdc(5'h10, 32'h01);
        rdc(5'h08, 32'hd0);
        rdc(5'h10, 32'h00);
        rdc(5'h0b, 32'h22);
        wr(5'h07, 32'h80);
        rdc(5'h0b, 32'h22);
        rdc(5'h10, 32'h01);
        rdc(5'h08, 32'h40);
        $display("test flow done");
    endtask : t_flow
    task automatic t_mode();
        wr(5'h04, 32'h04);
        // Host drops the invalid codes, so only the good write reaches the link
        wr(5'h04, 32'h01);
        wr(5'h04, 32'h02);
        wr(5'h04, 32'h03);
        wr(5'h04, 32'h07);
        check(rate_wr, 32'h1);
        rdc(5'h04, 32'h00);
        wr(5'h06, 32'h00);
        rx_byte(0, 8'h3c);
        rdc(5'h11, 32'h3c);
        $display("test serial done");
    endtask : t_mode
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    initial begin
        #160000;
        n_errors++;
        results();
    end
    initial begin
        RSTN = 1'b0;
        rx_mode = 1'b0;
        rx_tick = 2'h0;
        rx_ok = 2'h0;
        rx_bit = 2'h0;
        av_address = 5'h00;
        av_read = 1'b0;
        av_write = 1'b0;
        av_wdata = 32'h0;
        n_errors = 0;
        check_count = 0;
        repeat (8) @(posedge CLK);
        RSTN <= 1'b1;
        t_reset();
        rx_mode <= 1'b1;
        t_eof();
        t_drive();
        t_flow();
        t_mode();
        results();
    end
endmodule : test_rx_frame_irq_config
`default_nettype wire
